/* File: rtl/lio_pkg.sv */
// Shared constants for the legacy I/O positive decode block.
package lio_pkg;

    // Configuration offsets of the two device resource registers.
    localparam logic [7:0]  OFF_RES_A    = 8'h5c;
    localparam logic [7:0]  OFF_RES_B    = 8'h60;

    // Reset values; bit 27 of resource B is reserved and never stored.
    localparam logic [31:0] RST_RES_A    = 32'h0000_0000;
    localparam logic [31:0] RST_RES_B    = 32'h0000_0000;
    localparam logic [31:0] RES_B_WMASK  = 32'hf7ff_ffff;

    // Field positions in resource A.
    localparam int A_MUS_EN     = 0;
    localparam int A_MUS_SEL    = 1;
    localparam int A_SND_EN     = 3;
    localparam int A_JOY_EN     = 4;
    localparam int A_SND_SEL    = 5;
    localparam int A_COD_EN     = 7;
    localparam int A_COD_SEL    = 8;
    localparam int A_SND_FWD    = 25;
    localparam int A_KBD_EN     = 28;

    // Field positions in resource B.
    localparam int B_BASE       = 0;
    localparam int B_MASK       = 16;
    localparam int B_MUS_FWD    = 20;
    localparam int B_GEN_MON    = 21;
    localparam int B_GEN_FWD    = 22;
    localparam int B_GEN_CS     = 23;
    localparam int B_COD_FWD    = 24;
    localparam int B_LPT_SEL    = 25;
    localparam int B_FLP_SEL    = 28;
    localparam int B_FLP_FWD    = 29;
    localparam int B_KBD_FWD    = 30;
    localparam int B_JOY_FWD    = 31;

    // Sound card windows: base steps by 20h, main 16 bytes, aux 4 bytes.
    localparam logic [15:0] SND_BASE     = 16'h0220;
    localparam logic [15:0] SND_MAIN_LEN = 16'h000f;
    localparam logic [15:0] SND_AUX_OFF  = 16'h0010;
    localparam logic [15:0] SND_AUX_LEN  = 16'h0003;
    localparam logic [15:0] FM_LO        = 16'h0388;
    localparam logic [15:0] FM_HI        = 16'h038b;

    // Joystick, music and keyboard ports.
    localparam logic [15:0] JOY_LO       = 16'h0200;
    localparam logic [15:0] JOY_HI       = 16'h0207;
    localparam logic [15:0] MUS_BASE     = 16'h0300;
    localparam logic [15:0] MUS_LEN      = 16'h0003;
    localparam logic [15:0] KBD_DATA     = 16'h0060;
    localparam logic [15:0] KBD_CMD      = 16'h0064;

    // Floppy: six-byte block plus one extra port at offset 7.
    localparam logic [15:0] FLP_PRI      = 16'h03f0;
    localparam logic [15:0] FLP_SEC      = 16'h0370;
    localparam logic [15:0] FLP_LEN      = 16'h0005;
    localparam logic [15:0] FLP_XTRA     = 16'h0007;

    // Parallel port: main block and a three-byte block 400h above it.
    localparam logic [15:0] LPT_BASE0    = 16'h03bc;
    localparam logic [15:0] LPT_BASE1    = 16'h0378;
    localparam logic [15:0] LPT_BASE2    = 16'h0278;
    localparam logic [15:0] LPT_LEN0     = 16'h0003;
    localparam logic [15:0] LPT_LEN12    = 16'h0007;
    localparam logic [15:0] LPT_AUX_OFF  = 16'h0400;
    localparam logic [15:0] LPT_AUX_LEN  = 16'h0002;

    // Audio codec eight-byte windows.
    localparam logic [15:0] COD_BASE0    = 16'h0530;
    localparam logic [15:0] COD_BASE1    = 16'h0604;
    localparam logic [15:0] COD_BASE2    = 16'h0e80;
    localparam logic [15:0] COD_BASE3    = 16'h0f40;
    localparam logic [15:0] COD_LEN      = 16'h0007;

    // Index of each device in the monitor hit vector.
    localparam int NUM_DEV = 9;
    localparam int DEV_SND = 0;
    localparam int DEV_JOY = 1;
    localparam int DEV_MUS = 2;
    localparam int DEV_KBD = 3;
    localparam int DEV_FLP = 4;
    localparam int DEV_LPT = 5;
    localparam int DEV_COD = 6;
    localparam int DEV_GEN = 7;
    localparam int DEV_EC  = 8;

endpackage : lio_pkg

/* File: rtl/lio_range_cmp.sv */
`timescale 1ns/1ns
// Inclusive window comparator: hit when lo <= addr <= hi.
module lio_range_cmp #(
    parameter int W = 16
) (
    // Address and window bounds.
    input  wire logic [W-1:0] addr_i,
    input  wire logic [W-1:0] lo_i,
    input  wire logic [W-1:0] hi_i,
    // Match result.
    output logic              hit_o
);

    // Both end addresses belong to the window.
    assign hit_o = (addr_i >= lo_i) && (addr_i <= hi_i);

endmodule : lio_range_cmp

/* File: rtl/lio_cfg_regs.sv */
`timescale 1ns/1ns
// Configuration space holder for the two device resource registers.
module lio_cfg_regs (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Configuration access.
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_offset_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // Stored register values.
    output logic      [31:0] res_a_o,
    output logic      [31:0] res_b_o
);

    logic [31:0] res_a_q, res_a_d;   // Resource A contents.
    logic [31:0] res_b_q, res_b_d;   // Resource B contents.
    logic [31:0] rdata_q, rdata_d;   // Read data holding register.
    logic        rvalid_q, rvalid_d; // Read answer strobe.
    logic [31:0] be_mask;            // Byte enables widened to bits.

    // Byte enables pick which lanes a write replaces.
    always_comb begin
        be_mask  = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
        res_a_d  = res_a_q;
        res_b_d  = res_b_q;
        rdata_d  = rdata_q;
        rvalid_d = cfg_rd_i;
        if (cfg_wr_i && cfg_offset_i == lio_pkg::OFF_RES_A) begin
            res_a_d = (res_a_q & ~be_mask) | (cfg_wdata_i & be_mask);
        end
        if (cfg_wr_i && cfg_offset_i == lio_pkg::OFF_RES_B) begin
            // The reserved bit stays zero whatever is written.
            res_b_d = ((res_b_q & ~be_mask) | (cfg_wdata_i & be_mask)) & lio_pkg::RES_B_WMASK;
        end
        if (cfg_rd_i) begin
            // Unmapped offsets read as zero.
            unique case (cfg_offset_i)
                lio_pkg::OFF_RES_A: rdata_d = res_a_q;
                lio_pkg::OFF_RES_B: rdata_d = res_b_q;
                default:            rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Registers start cleared so every decode enabled from them begins disabled.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            res_a_q  <= lio_pkg::RST_RES_A;
            res_b_q  <= lio_pkg::RST_RES_B;
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            res_a_q  <= res_a_d;
            res_b_q  <= res_b_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign res_a_o      = res_a_q;
    assign res_b_o      = res_b_q;
    assign cfg_rdata_o  = rdata_q;
    assign cfg_rvalid_o = rvalid_q;

endmodule : lio_cfg_regs

/* File: rtl/lio_positive_decode.sv */
`timescale 1ns/1ns
// What this block does
// - Sound select picks one of four window pairs.
// - Joystick decode 200h-207h when enabled.
// - Sound decode adds synthesizer ports 388h-38Bh.
// - Music select picks one of four windows.
// - Music decode enable gates its window.
// - Joystick forward enable claims and forwards.
// - Keyboard forward claims ports 60h and 64h.
// - Floppy forward claims selected floppy range.
// - Floppy select: primary or secondary range.
// - Parallel select picks ranges; code 11 reserved.
// - Codec forward claims selected codec window.
// - Generic chip-select asserted inside generic range when forwarded.
// - Generic forward claims generic or controller range.
// - Generic monitor decodes base and mask range.
// - Music forward claims selected music window.
// - Resource B at 60h resets zero; bit 27 reserved.
// - Mask bits ignore address bits 3 to 0.
// - Base compares address bits 15 to 0.
module lio_positive_decode #(
    parameter logic [15:0] EC_BASE = 16'h0000, // Embedded controller window base.
    parameter logic [3:0]  EC_MASK = 4'h0      // Embedded controller ignored low bits.
) (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Configuration access.
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_offset_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // Enables held in other resource registers.
    input  wire logic        floppy_monitor_enable_i,
    input  wire logic        parallel_port_monitor_enable_i,
    input  wire logic        embedded_controller_enable_i,
    // PCI I/O cycle address phase.
    input  wire logic        io_cycle_i,
    input  wire logic [31:0] io_addr_i,
    // Decode results.
    output logic             claim_forward_o,
    output logic [8:0]       monitor_hit_o,
    output logic             programmable_chip_select_0_n_o
);

    // Window slots compared by the generate loop.
    localparam int W_SND  = 0;
    localparam int W_SNDX = 1;
    localparam int W_FM   = 2;
    localparam int W_JOY  = 3;
    localparam int W_MUS  = 4;
    localparam int W_KBD0 = 5;
    localparam int W_KBD1 = 6;
    localparam int W_FLP  = 7;
    localparam int W_FLPX = 8;
    localparam int W_LPT  = 9;
    localparam int W_LPTX = 10;
    localparam int W_COD  = 11;
    localparam int NWIN   = 12;

    logic [31:0] res_a;                    // Resource A contents.
    logic [31:0] res_b;                    // Resource B contents.
    logic [15:0] addr;                     // Low I/O address bits.
    logic        io_ok;                    // Valid I/O cycle in the 64K space.
    logic [15:0] win_lo [NWIN];            // Lower window bounds.
    logic [15:0] win_hi [NWIN];            // Upper window bounds.
    logic [NWIN-1:0] in_win;               // Per-window match.
    logic        lpt_ok;                   // Parallel select not reserved.
    logic [15:0] gen_ign;                  // Generic ignored address bits.
    logic [15:0] ec_ign;                   // Controller ignored address bits.
    logic        gen_match;                // Generic base and mask match.
    logic        ec_match;                 // Controller window match.
    logic [lio_pkg::NUM_DEV-1:0] dev_hit;  // Decoded per device.
    logic        fwd;                      // Claim and forward.
    logic        cs;                       // Generic chip-select.

    logic        claim_q, claim_d;         // Registered claim.
    logic [8:0]  hit_q, hit_d;             // Registered monitor hits.
    logic        cs_n_q, cs_n_d;           // Registered chip-select, low active.

    // Register storage and configuration answers.
    lio_cfg_regs u_regs (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .cfg_wr_i     (cfg_wr_i),
        .cfg_rd_i     (cfg_rd_i),
        .cfg_offset_i (cfg_offset_i),
        .cfg_be_i     (cfg_be_i),
        .cfg_wdata_i  (cfg_wdata_i),
        .cfg_rdata_o  (cfg_rdata_o),
        .cfg_rvalid_o (cfg_rvalid_o),
        .res_a_o      (res_a),
        .res_b_o      (res_b)
    );

    // Only I/O cycles inside the 16-bit port space are considered.
    assign addr  = io_addr_i[15:0];
    assign io_ok = io_cycle_i && (io_addr_i[31:16] == 16'h0000);

    // Window bounds follow the select fields.
    always_comb begin
        win_lo[W_SND]  = lio_pkg::SND_BASE + {9'h000, res_a[lio_pkg::A_SND_SEL +: 2], 5'h00};
        win_hi[W_SND]  = win_lo[W_SND] + lio_pkg::SND_MAIN_LEN;
        win_lo[W_SNDX] = win_lo[W_SND] + lio_pkg::SND_AUX_OFF;
        win_hi[W_SNDX] = win_lo[W_SNDX] + lio_pkg::SND_AUX_LEN;
        win_lo[W_FM]   = lio_pkg::FM_LO;
        win_hi[W_FM]   = lio_pkg::FM_HI;
        win_lo[W_JOY]  = lio_pkg::JOY_LO;
        win_hi[W_JOY]  = lio_pkg::JOY_HI;
        win_lo[W_MUS]  = lio_pkg::MUS_BASE + {10'h000, res_a[lio_pkg::A_MUS_SEL +: 2], 4'h0};
        win_hi[W_MUS]  = win_lo[W_MUS] + lio_pkg::MUS_LEN;
        win_lo[W_KBD0] = lio_pkg::KBD_DATA;
        win_hi[W_KBD0] = lio_pkg::KBD_DATA;
        win_lo[W_KBD1] = lio_pkg::KBD_CMD;
        win_hi[W_KBD1] = lio_pkg::KBD_CMD;
        // Floppy primary or secondary block plus its extra port.
        win_lo[W_FLP]  = res_b[lio_pkg::B_FLP_SEL] ? lio_pkg::FLP_SEC : lio_pkg::FLP_PRI;
        win_hi[W_FLP]  = win_lo[W_FLP] + lio_pkg::FLP_LEN;
        win_lo[W_FLPX] = win_lo[W_FLP] + lio_pkg::FLP_XTRA;
        win_hi[W_FLPX] = win_lo[W_FLPX];
        // Parallel port main block; the reserved code matches nothing.
        lpt_ok = 1'b1;
        unique case (res_b[lio_pkg::B_LPT_SEL +: 2])
            2'h0: begin
                win_lo[W_LPT] = lio_pkg::LPT_BASE0;
                win_hi[W_LPT] = lio_pkg::LPT_BASE0 + lio_pkg::LPT_LEN0;
            end
            2'h1: begin
                win_lo[W_LPT] = lio_pkg::LPT_BASE1;
                win_hi[W_LPT] = lio_pkg::LPT_BASE1 + lio_pkg::LPT_LEN12;
            end
            2'h2: begin
                win_lo[W_LPT] = lio_pkg::LPT_BASE2;
                win_hi[W_LPT] = lio_pkg::LPT_BASE2 + lio_pkg::LPT_LEN12;
            end
            2'h3: begin
                win_lo[W_LPT] = lio_pkg::LPT_BASE0;
                win_hi[W_LPT] = lio_pkg::LPT_BASE0;
                lpt_ok        = 1'b0;
            end
        endcase
        win_lo[W_LPTX] = win_lo[W_LPT] + lio_pkg::LPT_AUX_OFF;
        win_hi[W_LPTX] = win_lo[W_LPTX] + lio_pkg::LPT_AUX_LEN;
        // Audio codec eight-byte window.
        unique case (res_a[lio_pkg::A_COD_SEL +: 2])
            2'h0: win_lo[W_COD] = lio_pkg::COD_BASE0;
            2'h1: win_lo[W_COD] = lio_pkg::COD_BASE1;
            2'h2: win_lo[W_COD] = lio_pkg::COD_BASE2;
            2'h3: win_lo[W_COD] = lio_pkg::COD_BASE3;
        endcase
        win_hi[W_COD] = win_lo[W_COD] + lio_pkg::COD_LEN;
    end

    // One inclusive comparator per window.
    for (genvar g = 0; g < NWIN; g++) begin : g_win
        lio_range_cmp #(.W(16)) u_cmp (
            .addr_i (addr),
            .lo_i   (win_lo[g]),
            .hi_i   (win_hi[g]),
            .hit_o  (in_win[g])
        );
    end

    // Masked matches: a set mask bit drops that low address bit.
    assign gen_ign   = {12'h000, res_b[lio_pkg::B_MASK +: 4]};
    assign ec_ign    = {12'h000, EC_MASK};
    assign gen_match = ((addr ^ res_b[lio_pkg::B_BASE +: 16]) & ~gen_ign) == 16'h0000;
    assign ec_match  = ((addr ^ EC_BASE) & ~ec_ign) == 16'h0000;

    // Per-device decode, each gated by its own enable.
    always_comb begin
        dev_hit = '0;
        dev_hit[lio_pkg::DEV_SND] = res_a[lio_pkg::A_SND_EN] && |in_win[W_FM:W_SND];
        dev_hit[lio_pkg::DEV_JOY] = res_a[lio_pkg::A_JOY_EN] && in_win[W_JOY];
        dev_hit[lio_pkg::DEV_MUS] = res_a[lio_pkg::A_MUS_EN] && in_win[W_MUS];
        dev_hit[lio_pkg::DEV_KBD] = res_a[lio_pkg::A_KBD_EN] && (in_win[W_KBD0] || in_win[W_KBD1]);
        dev_hit[lio_pkg::DEV_FLP] = floppy_monitor_enable_i && (in_win[W_FLP] || in_win[W_FLPX]);
        dev_hit[lio_pkg::DEV_LPT] = parallel_port_monitor_enable_i && lpt_ok
                                    && (in_win[W_LPT] || in_win[W_LPTX]);
        dev_hit[lio_pkg::DEV_COD] = res_a[lio_pkg::A_COD_EN] && in_win[W_COD];
        dev_hit[lio_pkg::DEV_GEN] = res_b[lio_pkg::B_GEN_MON] && gen_match;
        dev_hit[lio_pkg::DEV_EC]  = embedded_controller_enable_i && ec_match;
        if (!io_ok) begin
            dev_hit = '0;
        end
    end

    // Forwarding needs both the decode and the device forward enable.
    always_comb begin
        fwd = (dev_hit[lio_pkg::DEV_SND] && res_a[lio_pkg::A_SND_FWD])
           || (dev_hit[lio_pkg::DEV_JOY] && res_b[lio_pkg::B_JOY_FWD])
           || (dev_hit[lio_pkg::DEV_KBD] && res_b[lio_pkg::B_KBD_FWD])
           || (dev_hit[lio_pkg::DEV_FLP] && res_b[lio_pkg::B_FLP_FWD])
           || (dev_hit[lio_pkg::DEV_COD] && res_b[lio_pkg::B_COD_FWD])
           || (dev_hit[lio_pkg::DEV_MUS] && res_b[lio_pkg::B_MUS_FWD])
           || ((dev_hit[lio_pkg::DEV_GEN] || dev_hit[lio_pkg::DEV_EC])
               && res_b[lio_pkg::B_GEN_FWD]);
        // Chip-select covers the generic range only, not the controller.
        cs = dev_hit[lio_pkg::DEV_GEN] && res_b[lio_pkg::B_GEN_FWD] && res_b[lio_pkg::B_GEN_CS];
    end

    // Next output values, taken one cycle after the address phase.
    always_comb begin
        claim_d = fwd;
        hit_d   = dev_hit;
        cs_n_d  = !cs;
    end

    // Outputs come straight from flip-flops.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            claim_q <= 1'b0;
            hit_q   <= 9'h000;
            cs_n_q  <= 1'b1;
        end else begin
            claim_q <= claim_d;
            hit_q   <= hit_d;
            cs_n_q  <= cs_n_d;
        end
    end

    assign claim_forward_o                = claim_q;
    assign monitor_hit_o                  = hit_q;
    assign programmable_chip_select_0_n_o = cs_n_q;

    // Checks on the decode, sampled on the system clock.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_reset_clears: assert property (disable iff (1'b0) !rst_n_i |=> res_b == 32'h0000_0000)
        else $error("Resource B not cleared by reset");
    a_sound_aux_end: assert property (io_cycle_i && io_addr_i == 32'h0000_0233
        && res_a[6:5] == 2'h0 && res_a[3] && res_a[25] |=> claim_forward_o)
        else $error("Sound aux window end not claimed");
    a_synth_port: assert property (io_cycle_i && io_addr_i == 32'h0000_038b
        && res_a[3] |=> monitor_hit_o[0])
        else $error("Synthesizer port not decoded");
    a_joystick_fwd: assert property (io_cycle_i && io_addr_i == 32'h0000_0207
        && res_a[4] && res_b[31] |=> claim_forward_o)
        else $error("Joystick access not claimed");
    a_music_window: assert property (io_cycle_i && io_addr_i == 32'h0000_0333
        && res_a[2:1] == 2'h3 && res_a[0] && res_b[20] |=> claim_forward_o)
        else $error("Music window not claimed");
    a_floppy_extra: assert property (io_cycle_i && io_addr_i == 32'h0000_0377
        && res_b[28] && res_b[29] && floppy_monitor_enable_i |=> claim_forward_o)
        else $error("Secondary floppy extra port not claimed");
    a_lpt_reserved: assert property (res_b[26:25] == 2'h3 |=> !monitor_hit_o[5])
        else $error("Reserved parallel select matched");
    a_cs_needs_fwd: assert property (!programmable_chip_select_0_n_o |-> $past(res_b[23] && res_b[22]))
        else $error("Chip-select without its enables");
    a_generic_mask: assert property (io_cycle_i && io_addr_i[31:16] == 16'h0000
        && ((io_addr_i[15:0] ^ res_b[15:0]) & 16'hfff0) == 16'h0000 && res_b[19:16] == 4'hf
        && res_b[21] && res_b[22] |=> claim_forward_o)
        else $error("Masked generic access not claimed");
    a_idle_quiet: assert property (!io_cycle_i |=> !claim_forward_o && monitor_hit_o == 9'h000)
        else $error("Claim without an I/O cycle");

    c_keyboard: cover property (io_cycle_i && res_b[30] ##1 claim_forward_o);
    c_generic_cs: cover property (!programmable_chip_select_0_n_o);
    c_codec: cover property (monitor_hit_o[6] && claim_forward_o);

endmodule : lio_positive_decode

/* File: sim/lio_pci_master.sv */
`timescale 1ns/1ns
// Stand-in for the PCI master: one address phase for each bench request.
module lio_pci_master (
    // Clock and request from the bench.
    input  wire logic        sys_clk_i,
    input  wire logic        go_i,
    input  wire logic [31:0] addr_i,
    // Address phase towards the decoder.
    output logic             io_cycle_o,
    output logic      [31:0] io_addr_o
);
    initial io_cycle_o = 1'b0;
    initial io_addr_o = 32'h0000_0000;
    // Between cycles the address lines flip, so a stale address never passes for a real one.
    always @(negedge sys_clk_i) begin
        io_cycle_o <= go_i;
        io_addr_o  <= go_i ? addr_i : ~io_addr_o;
    end
endmodule : lio_pci_master

/* File: sim/tb_lio_positive_decode.sv */
`timescale 1ns/1ns
// Self-checking bench for the positive decode block.
module tb_lio_positive_decode;
    // Clock, reset and design inputs; all but the floppy, parallel and controller enables driven on the falling edge.
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0]  off = 8'h00;
    logic [3:0]  be = 4'h0;
    logic [31:0] wd = 32'h0;
    logic        flp = 1'b0, lpt = 1'b0, ec = 1'b0, go = 1'b0;
    logic [31:0] ga = 32'h0;
    // Design outputs and address phase lines.
    logic [31:0] rdat, io_addr;
    logic        rv, io_cyc, claim, cs_n;
    logic [8:0]  hits;
    logic [15:0] cb [4] = '{16'h0530, 16'h0604, 16'h0e80, 16'h0f40};
    logic [15:0] lp [3] = '{16'h03bc, 16'h0378, 16'h0278};
    logic [15:0] lh [3] = '{16'h0003, 16'h0007, 16'h0007};
    logic [15:0] a;
    int          mismatches = 0;
    int          total_checks = 0;
    localparam logic [7:0] RA = 8'h5c;
    localparam logic [7:0] RB = 8'h60;

    always #5 sys_clk_i = ~sys_clk_i;

    lio_pci_master PM (.sys_clk_i(sys_clk_i), .go_i(go), .addr_i(ga), .io_cycle_o(io_cyc), .io_addr_o(io_addr));

    lio_positive_decode #(.EC_BASE(16'h0480), .EC_MASK(4'h1)) DUT (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_offset_i(off), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv),
        .floppy_monitor_enable_i(flp), .parallel_port_monitor_enable_i(lpt),
        .embedded_controller_enable_i(ec), .io_cycle_i(io_cyc), .io_addr_i(io_addr),
        .claim_forward_o(claim), .monitor_hit_o(hits), .programmable_chip_select_0_n_o(cs_n));

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Compares one seen value with its expectation.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One configuration write, a single-cycle strobe.
    task automatic cw(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
        @(negedge sys_clk_i);
        wr <= 1'b1;
        off <= o;
        be <= b;
        wd <= d;
        @(negedge sys_clk_i);
        wr <= 1'b0;
    endtask : cw

    // One configuration read; the answer stands for exactly one cycle.
    task automatic cr(input logic [7:0] o, input logic [31:0] exp);
        @(negedge sys_clk_i);
        rd <= 1'b1;
        off <= o;
        @(negedge sys_clk_i);
        rd <= 1'b0;
        #1;
        chk(32'(rv), 32'h1);
        chk(rdat, exp);
        @(negedge sys_clk_i);
        chk(32'(rv), 32'h0);
    endtask : cr

    // One I/O address phase, then the registered claim, chip-select and hits.
    task automatic pr(input logic c, input logic [31:0] ad, input logic cl, input logic [8:0] h, input logic s);
        @(negedge sys_clk_i);
        go <= c;
        ga <= ad;
        @(negedge sys_clk_i);
        go <= 1'b0;
        @(negedge sys_clk_i);
        #1;
        chk(32'({claim, cs_n}), 32'({cl, s}));
        chk(32'(hits), 32'(h));
    endtask : pr

    // Watchdog well beyond the expected run length.
    initial begin
        #100000;
        mismatches++;
        close_out();
    end

    // Main sequence.
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        cr(RA, 32'h0);
        cr(RB, 32'h0);
        cr(8'h64, 32'h0);
        pr(1'b1, 32'h0203, 1'b0, 9'h000, 1'b1);
        cw(RB, 4'hf, 32'hffff_ffff);
        cr(RB, 32'hf7ff_ffff);
        cw(RB, 4'h1, 32'h0);
        cr(RB, 32'hf7ff_ff00);
        $display("test registers done");
        cw(RB, 4'hf, 32'hc010_0000);
        for (int s = 0; s < 4; s++) begin
            cw(RA, 4'hf, 32'h1200_0099 | (s << 5) | (s << 1) | (s << 8));
            a = 16'h0220 + 16'(32 * s);
            pr(1'b1, 32'(a), 1'b1, 9'h001, 1'b1);
            pr(1'b1, 32'(a + 16'h0f), 1'b1, 9'h001, 1'b1);
            pr(1'b1, 32'(a + 16'h13), 1'b1, 9'h001, 1'b1);
            pr(1'b1, 32'(a + 16'h14), 1'b0, 9'h000, 1'b1);
            a = 16'h0300 + 16'(16 * s);
            pr(1'b1, 32'(a + 16'h03), 1'b1, 9'h004, 1'b1);
            pr(1'b1, 32'(a + 16'h04), 1'b0, 9'h000, 1'b1);
            pr(1'b1, 32'(cb[s] + 16'h07), 1'b0, 9'h040, 1'b1);
        end
        $display("test range selects done");
        pr(1'b1, 32'h0207, 1'b1, 9'h002, 1'b1);
        pr(1'b1, 32'h0208, 1'b0, 9'h000, 1'b1);
        pr(1'b1, 32'h0064, 1'b1, 9'h008, 1'b1);
        pr(1'b1, 32'h0061, 1'b0, 9'h000, 1'b1);
        pr(1'b1, 32'h038b, 1'b1, 9'h001, 1'b1);
        pr(1'b1, 32'h038c, 1'b0, 9'h000, 1'b1);
        pr(1'b0, 32'h0200, 1'b0, 9'h000, 1'b1);
        pr(1'b1, 32'h0001_0060, 1'b0, 9'h000, 1'b1);
        cw(RB, 4'hf, 32'h8100_0000);
        pr(1'b1, 32'h0f40, 1'b1, 9'h040, 1'b1);
        pr(1'b1, 32'h0330, 1'b0, 9'h004, 1'b1);
        pr(1'b1, 32'h0060, 1'b0, 9'h008, 1'b1);
        cw(RA, 4'hf, 32'h0);
        pr(1'b1, 32'h0200, 1'b0, 9'h000, 1'b1);
        $display("test forwarding done");
        flp = 1'b1;
        cw(RB, 4'hf, 32'h2000_0000);
        pr(1'b1, 32'h03f5, 1'b1, 9'h010, 1'b1);
        pr(1'b1, 32'h03f6, 1'b0, 9'h000, 1'b1);
        pr(1'b1, 32'h03f7, 1'b1, 9'h010, 1'b1);
        cw(RB, 4'hf, 32'h3000_0000);
        pr(1'b1, 32'h0377, 1'b1, 9'h010, 1'b1);
        pr(1'b1, 32'h03f0, 1'b0, 9'h000, 1'b1);
        flp = 1'b0;
        pr(1'b1, 32'h0370, 1'b0, 9'h000, 1'b1);
        $display("test floppy done");
        lpt = 1'b1;
        for (int s = 0; s < 3; s++) begin
            cw(RB, 4'hf, 32'(s) << 25);
            pr(1'b1, 32'(lp[s] + lh[s]), 1'b0, 9'h020, 1'b1);
            pr(1'b1, 32'(lp[s] + 16'h0402), 1'b0, 9'h020, 1'b1);
            pr(1'b1, 32'(lp[s] + 16'h0403), 1'b0, 9'h000, 1'b1);
        end
        cw(RB, 4'hf, 32'h0600_0000);
        pr(1'b1, 32'h03bc, 1'b0, 9'h000, 1'b1);
        lpt = 1'b0;
        $display("test parallel done");
        cw(RB, 4'hf, 32'h00e3_0100);
        pr(1'b1, 32'h0103, 1'b1, 9'h080, 1'b0);
        pr(1'b1, 32'h0104, 1'b0, 9'h000, 1'b1);
        cw(RB, 4'hf, 32'h00e9_0100);
        pr(1'b1, 32'h0109, 1'b1, 9'h080, 1'b0);
        pr(1'b1, 32'h0102, 1'b0, 9'h000, 1'b1);
        cw(RB, 4'hf, 32'h0060_0100);
        pr(1'b1, 32'h0100, 1'b1, 9'h080, 1'b1);
        cw(RB, 4'hf, 32'h00a0_0100);
        pr(1'b1, 32'h0100, 1'b0, 9'h080, 1'b1);
        ec = 1'b1;
        cw(RB, 4'hf, 32'h0040_0000);
        pr(1'b1, 32'h0481, 1'b1, 9'h100, 1'b1);
        pr(1'b1, 32'h0482, 1'b0, 9'h000, 1'b1);
        $display("test generic done");
        close_out();
    end
endmodule : tb_lio_positive_decode
